//--- rtl/sfc_map.vh
// constants for the setup filter configuration bank
// assumes byte addressing on a 32-bit apb bus, one word per register
`ifndef SFC_MAP_VH
`define SFC_MAP_VH
// register indices; byte address is four times the index
`define SFC_IDX_SETUP0      8'h21
`define SFC_IDX_SETUP7      8'h28
`define SFC_IDX_CTRL        8'h40
`define SFC_IDX_STATUS      8'h41
// field layout of a setup register
`define SFC_WAIT_HI         23
`define SFC_WAIT_LO         21
`define SFC_REP_HI          20
`define SFC_REP_LO          16
`define SFC_FILT_HI         15
`define SFC_FILT_LO         12
`define SFC_RATE_HI         10
`define SFC_RATE_LO         0
`define SFC_CFG_RESET       24'h00_2030
`define SFC_CFG_WMASK       24'hFF_F7FF
// settling base: 32 master clock cycles at code 000
`define SFC_WAIT_BASE       13'h0020
`define SFC_FILT_LAST_OK    4'h8
`endif

//--- rtl/sfc_cfg_mem.v
// eight setup configuration words with registered read port
// assumes a single clock; writes mask out the reserved bit
`timescale 1ns/10ps
`default_nettype none
`include "sfc_map.vh"
module sfc_cfg_mem #(
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire            clk,
  input  wire            rst,
  // write port
  input  wire            wr_en,
  input  wire [AW-1:0]   wr_addr,
  input  wire [23:0]     wr_data,
  // registered read port
  input  wire [AW-1:0]   rd_addr,
  output reg  [23:0]     rd_data_ff,
  // flat view of all words for the sequencer
  output wire [DEPTH*24-1:0] all_words
);
  genvar g;
  // ***************************************
  // storage, one generate entry per setup
  // ***************************************
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : gen_word
      reg [23:0] word_ff;
      // reset value and masked write
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          word_ff <= `SFC_CFG_RESET;
        end else if (wr_en && wr_addr == g) begin
          word_ff <= wr_data & `SFC_CFG_WMASK;
        end
      end
      assign all_words[g*24 +: 24] = word_ff;
    end
  endgenerate
  // read data from a register
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= 24'h00_0000;
    end else begin
      rd_data_ff <= all_words[rd_addr*24 +: 24];
    end
  end
endmodule
`default_nettype wire

//--- rtl/sfc_wait_timer.v
// settling wait counter started at each channel switch
// assumes start is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
`include "sfc_map.vh"
module sfc_wait_timer (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // control
  input  wire        start,
  input  wire [2:0]  wait_sel,
  // status
  output wire        busy,
  output wire        done
);
  reg  [12:0] cnt_ff;
  reg  [12:0] nxt_cnt;
  reg         run_ff;
  reg         nxt_run;
  // doubling per code step from 32 cycles
  wire [12:0] span = `SFC_WAIT_BASE << wait_sel;
  // count cycles from the switch
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    if (start) begin
      nxt_cnt = span - 13'h0001;
      nxt_run = 1'b1;
    end else if (run_ff) begin
      if (cnt_ff == 13'h0000) begin
        nxt_run = 1'b0;
      end else begin
        nxt_cnt = cnt_ff - 13'h0001;
      end
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 13'h0000;
      run_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
    end
  end
  assign busy = run_ff;
  assign done = run_ff && (cnt_ff == 13'h0000);
endmodule
`default_nettype wire

//--- rtl/sfc_bank.v
// setup filter configuration bank with channel sequencing control
// assumes apb master on MCLK; sequencer handshakes are synchronous
`timescale 1ns/10ps
`default_nettype none
`include "sfc_map.vh"
module sfc_bank (
  // clock and reset
  input  wire        MCLK,
  input  wire        RST,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  // sequencer request
  input  wire        SEQ_CH_REQ,
  input  wire [2:0]  SEQ_SETUP,
  input  wire        DUTY_CYCLE_ON,
  input  wire        CAL_ACTIVE,
  input  wire        CONV_DONE,
  // conversion control
  output wire        CH_REQ_READY,
  output wire        CONV_START,
  output reg  [3:0]  FILTER_TYPE,
  output reg         FILTER_VALID,
  output reg  [10:0] OUTPUT_RATE_SEL,
  output wire        CH_FINISHED
);
  // ***************************************
  // states, one-hot
  // ***************************************
  localparam [4:0] ST_IDLE  = 5'b00001;
  localparam [4:0] ST_WAIT  = 5'b00010;
  localparam [4:0] ST_START = 5'b00100;
  localparam [4:0] ST_CONV  = 5'b01000;
  localparam [4:0] ST_DONE  = 5'b10000;

  reg  [4:0]   state_ff;
  reg  [4:0]   nxt_state;
  reg  [4:0]   rep_ff;
  reg  [4:0]   nxt_rep;
  reg  [2:0]   setup_ff;
  reg  [2:0]   nxt_setup;
  reg          rd_phase_ff;
  reg          enable_ff;
  reg  [31:0]  rdata_ff;
  wire [23:0]  mem_rd;
  wire [191:0] words;
  wire         wait_busy;
  wire         wait_done;
  wire [23:0]  cur_cfg;
  wire [7:0]   idx;
  wire         hit_cfg;
  wire         hit_ctrl;
  wire         hit_stat;
  wire         acc;
  wire         single_only;
  wire         start_wait;

  // ***************************************
  // apb decode
  // ***************************************
  // word index from byte address
  assign idx      = PADDR[9:2];
  assign hit_cfg  = (idx >= `SFC_IDX_SETUP0) && (idx <= `SFC_IDX_SETUP7)
                    && (PADDR[11:10] == 2'b00);
  assign hit_ctrl = (idx == `SFC_IDX_CTRL) && (PADDR[11:10] == 2'b00);
  assign hit_stat = (idx == `SFC_IDX_STATUS) && (PADDR[11:10] == 2'b00);
  assign acc      = PSEL && PENABLE;
  // config reads need one wait state for the registered memory port
  assign PREADY   = !(acc && !PWRITE && hit_cfg && !rd_phase_ff);
  assign PSLVERR  = acc && PREADY && !(hit_cfg || hit_ctrl || hit_stat);
  assign PRDATA   = rdata_ff;

  // setup words held in the memory
  sfc_cfg_mem #(
    .DEPTH (8),
    .AW    (3)
  ) u_mem (
    .clk        (MCLK),
    .rst        (RST),
    .wr_en      (acc && PWRITE && hit_cfg),
    .wr_addr    (idx[2:0] - 3'h1),
    .wr_data    (PWDATA[23:0]),
    .rd_addr    (idx[2:0] - 3'h1),
    .rd_data_ff (mem_rd),
    .all_words  (words)
  );

  // read phase flag, control register and read data
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rd_phase_ff <= 1'b0;
      enable_ff   <= 1'b0;
      rdata_ff    <= 32'h0000_0000;
    end else begin
      rd_phase_ff <= acc && !PWRITE && hit_cfg && !rd_phase_ff;
      if (acc && PWRITE && hit_ctrl) begin
        enable_ff <= PWDATA[0];
      end
      if (acc && !PWRITE && PREADY) begin
        if (hit_cfg) begin
          rdata_ff <= {8'h00, mem_rd};
        end else if (hit_ctrl) begin
          rdata_ff <= {31'h0000_0000, enable_ff};
        end else if (hit_stat) begin
          rdata_ff <= {19'h0_0000, rep_ff, setup_ff, state_ff};
        end else begin
          rdata_ff <= 32'h0000_0000;
        end
      end
    end
  end

  // ***************************************
  // channel sequencing
  // ***************************************
  assign cur_cfg = words[SEQ_SETUP*24 +: 24];
  // single conversion in duty cycling or calibration
  assign single_only  = DUTY_CYCLE_ON || CAL_ACTIVE;
  assign CH_REQ_READY = enable_ff && state_ff[0];
  // every channel switch starts the wait
  assign start_wait   = CH_REQ_READY && SEQ_CH_REQ;

  sfc_wait_timer u_wait (
    .clk      (MCLK),
    .rst      (RST),
    .start    (start_wait),
    .wait_sel (cur_cfg[`SFC_WAIT_HI:`SFC_WAIT_LO]),
    .busy     (wait_busy),
    .done     (wait_done)
  );

  // next state of the sequencer
  always @* begin
    nxt_state = state_ff;
    nxt_rep   = rep_ff;
    nxt_setup = setup_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_wait) begin
          // reload repeat count at channel change
          nxt_setup = SEQ_SETUP;
          nxt_rep   = single_only ? 5'h00 : cur_cfg[`SFC_REP_HI:`SFC_REP_LO];
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_done) begin
          nxt_state = ST_START;
        end
      end
      ST_START: begin
        nxt_state = ST_CONV;
      end
      ST_CONV: begin
        if (CONV_DONE) begin
          if (rep_ff == 5'h00 || single_only) begin
            nxt_state = ST_DONE;
          end else begin
            nxt_rep   = rep_ff - 5'h01;
            nxt_state = ST_START;
          end
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // sequencer registers and per-setup filter outputs
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_ff        <= ST_IDLE;
      rep_ff          <= 5'h00;
      setup_ff        <= 3'h0;
      FILTER_TYPE     <= 4'h2;
      FILTER_VALID    <= 1'b1;
      OUTPUT_RATE_SEL <= 11'h030;
    end else begin
      state_ff <= nxt_state;
      rep_ff   <= nxt_rep;
      setup_ff <= nxt_setup;
      FILTER_TYPE <= words[nxt_setup*24 + `SFC_FILT_LO +: 4];
      FILTER_VALID <= (words[nxt_setup*24 + `SFC_FILT_LO +: 4] <= `SFC_FILT_LAST_OK);
      if (words[nxt_setup*24 +: 11] == 11'h000) begin
        OUTPUT_RATE_SEL <= 11'h001;
      end else begin
        OUTPUT_RATE_SEL <= words[nxt_setup*24 +: 11];
      end
    end
  end

  assign CONV_START  = state_ff[2];
  assign CH_FINISHED = state_ff[4];
endmodule
`default_nettype wire

//--- tb/sfc_bank_chk.sv
// port assertions for the setup filter bank
// assumes it is bound to sfc_bank and runs on MCLK alone
`timescale 1ns/10ps
`default_nettype none
`include "sfc_map.vh"
module sfc_bank_chk (
  // clock and reset
  input wire        MCLK, RST,
  // apb
  input wire        PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  input wire [11:0] PADDR,
  // sequencer
  input wire        SEQ_CH_REQ, DUTY_CYCLE_ON, CAL_ACTIVE, CONV_DONE,
  input wire        CH_REQ_READY, CONV_START, FILTER_VALID, CH_FINISHED,
  input wire [3:0]  FILTER_TYPE,
  input wire [10:0] OUTPUT_RATE_SEL
);
  logic [12:0] cnt_ff;
  logic        first_ff;
  logic        conv_ff;
  wire         take = SEQ_CH_REQ && CH_REQ_READY;
  wire         set_rd = PSEL && !PENABLE && !PWRITE && PADDR[11:10] == 2'b00
                        && PADDR[9:2] >= `SFC_IDX_SETUP0 && PADDR[9:2] <= `SFC_IDX_SETUP7;
  // ************************************************************
  // cycles since a channel was taken, conversion in flight
  // ************************************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cnt_ff <= 13'h0000;
      first_ff <= 1'b0;
      conv_ff <= 1'b0;
    end else begin
      cnt_ff <= take ? 13'h0001 : (cnt_ff == 13'h1FFF ? cnt_ff : cnt_ff + 13'h0001);
      first_ff <= take ? 1'b1 : (CONV_START ? 1'b0 : first_ff);
      conv_ff <= CONV_START ? 1'b1 : (CONV_DONE ? 1'b0 : conv_ff);
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // wait is a power of two from 32 to 4096, plus the start cycle
  chk_wait_len: assert property (CONV_START && first_ff |-> cnt_ff >= 13'h0021
    && cnt_ff <= 13'h1001 && ((cnt_ff - 13'h0001) & (cnt_ff - 13'h0002)) == 13'h0000)
    else $error("settling wait length wrong");
  chk_start_held: assert property (take |=> !CONV_START [*8])
    else $error("start during settling");
  chk_req_busy: assert property (take |=> !CH_REQ_READY)
    else $error("request accepted while busy");
  chk_repeat_nowait: assert property (conv_ff && CONV_DONE |=> CONV_START != CH_FINISHED)
    else $error("no restart or finish after done");
  chk_single_forced: assert property (conv_ff && CONV_DONE && (DUTY_CYCLE_ON || CAL_ACTIVE)
    |=> CH_FINISHED && !CONV_START) else $error("repeat while duty or cal");
  chk_rate_nonzero: assert property (OUTPUT_RATE_SEL != 11'h000)
    else $error("rate zero passed on");
  chk_filt_valid: assert property (FILTER_VALID == (FILTER_TYPE <= `SFC_FILT_LAST_OK))
    else $error("filter valid flag wrong");
  chk_setup_rdwait: assert property (set_rd |=> !PREADY ##1 PREADY)
    else $error("setup read wait state wrong");
  chk_err_timing: assert property (PSLVERR |-> PSEL && PENABLE && PREADY)
    else $error("error outside access phase");
endmodule
bind sfc_bank sfc_bank_chk i_chk (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PADDR(PADDR),
  .SEQ_CH_REQ(SEQ_CH_REQ), .DUTY_CYCLE_ON(DUTY_CYCLE_ON), .CAL_ACTIVE(CAL_ACTIVE),
  .CONV_DONE(CONV_DONE), .CH_REQ_READY(CH_REQ_READY), .CONV_START(CONV_START),
  .FILTER_VALID(FILTER_VALID), .CH_FINISHED(CH_FINISHED), .FILTER_TYPE(FILTER_TYPE),
  .OUTPUT_RATE_SEL(OUTPUT_RATE_SEL));
`default_nettype wire

//--- tb/tb_sfc_bank.sv
// self-checking bench for the setup filter bank
// assumes apb master and sequencer are driven here directly
`timescale 1ns/10ps
`default_nettype none
module tb_sfc_bank;
  logic        MCLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic        SEQ_CH_REQ = 0, DUTY_CYCLE_ON = 0, CAL_ACTIVE = 0, CONV_DONE = 0;
  logic [2:0]  SEQ_SETUP = 3'h0;
  wire  [31:0] PRDATA;
  wire         PREADY, PSLVERR, CH_REQ_READY, CONV_START, FILTER_VALID, CH_FINISHED;
  wire  [3:0]  FILTER_TYPE;
  wire  [10:0] OUTPUT_RATE_SEL;
  int          bad_count = 0;
  int          samples_checked = 0;
  sfc_bank i_dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SEQ_CH_REQ(SEQ_CH_REQ), .SEQ_SETUP(SEQ_SETUP), .DUTY_CYCLE_ON(DUTY_CYCLE_ON),
    .CAL_ACTIVE(CAL_ACTIVE), .CONV_DONE(CONV_DONE), .CH_REQ_READY(CH_REQ_READY),
    .CONV_START(CONV_START), .FILTER_TYPE(FILTER_TYPE), .FILTER_VALID(FILTER_VALID),
    .OUTPUT_RATE_SEL(OUTPUT_RATE_SEL), .CH_FINISHED(CH_FINISHED));
  always #4 MCLK = ~MCLK;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ************************************************************
  // apb transfer; read data lands just after the completing edge
  // ************************************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge MCLK);
    PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    #1;
    while (PREADY !== 1'b1) begin
      @(posedge MCLK);
      #1;
    end
    e = PSLVERR;
    @(posedge MCLK);
    PSEL <= 1'b0; PENABLE <= 1'b0;
    #1 r = PRDATA;
  endtask
  // reset values, reserved bit, unmapped address, enable
  task automatic test_regs;
    logic [31:0] r;
    logic        e;
    check(CH_REQ_READY, 0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(12'h084 + 4 * i), 32'h0000_0000, r, e);
      check(r, 32'h0000_2030);
      check(e, 0);
    end
    apb(1'b1, 12'h090, 32'hFFFF_FFFF, r, e);
    apb(1'b0, 12'h090, 32'h0000_0000, r, e);
    check(r, 32'h00FF_F7FF);
    apb(1'b0, 12'h200, 32'h0000_0000, r, e);
    check(e, 1);
    check(r, 0);
    apb(1'b1, 12'h100, 32'h0000_0001, r, e);
  endtask
  // one channel: program setup, request, time the wait, count starts
  task automatic run_ch(input logic [2:0] s, input logic [23:0] cfg, input logic duty,
                        input logic cal, input int starts);
    logic [31:0] r;
    logic        e;
    int          n;
    apb(1'b1, 12'(12'h084 + 4 * s), {8'h00, cfg}, r, e);
    DUTY_CYCLE_ON <= duty; CAL_ACTIVE <= cal;
    @(posedge MCLK);
    SEQ_CH_REQ <= 1'b1; SEQ_SETUP <= s;
    #1 check(CH_REQ_READY, 1);
    @(posedge MCLK);
    SEQ_CH_REQ <= 1'b0;
    #1 n = 0;
    while (CONV_START !== 1'b1 && n < 5000) begin
      @(posedge MCLK);
      #1 n++;
    end
    check(n, 32 << cfg[23:21]);
    check(FILTER_TYPE, cfg[15:12]);
    check(FILTER_VALID, cfg[15:12] <= 4'h8);
    check(OUTPUT_RATE_SEL, cfg[10:0] == 11'h000 ? 11'h001 : cfg[10:0]);
    for (int k = 1; k <= starts; k++) begin
      @(posedge MCLK);
      CONV_DONE <= 1'b1;
      @(posedge MCLK);
      CONV_DONE <= 1'b0;
      #1 check(CONV_START, k < starts);
      check(CH_FINISHED, k == starts);
    end
    repeat (2) @(posedge MCLK);
  endtask
  // every settling code on its own setup, rate zero, sinc4 code
  task automatic test_waits;
    for (int c = 0; c < 8; c++)
      run_ch(3'(c), {3'(c), 5'h00, 4'h0, 12'h000}, 1'b0, 1'b0, 1);
  endtask
  // top repeat count, forced single, reload after channel change
  task automatic test_repeats;
    run_ch(3'h5, {3'h0, 5'h1F, 4'h8, 12'h010}, 1'b0, 1'b0, 32);
    run_ch(3'h6, {3'h1, 5'h02, 4'h9, 12'h7FF}, 1'b0, 1'b0, 3);
    run_ch(3'h6, {3'h1, 5'h02, 4'h9, 12'h7FF}, 1'b1, 1'b0, 1);
    run_ch(3'h6, {3'h1, 5'h02, 4'h9, 12'h7FF}, 1'b0, 1'b1, 1);
    run_ch(3'h6, {3'h1, 5'h02, 4'hF, 12'h7FF}, 1'b0, 1'b0, 3);
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog sized well above the settling sweep
  initial begin
    #(8 * 40000);
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    test_regs;
    test_waits;
    test_repeats;
    print_verdict;
  end
endmodule
`default_nettype wire
